// *** rtl/chan_cfg_consts.vh ***
/*
  Constants for the channel-pair and sync-word configuration bank.
  Assumes a word-aligned Avalon-MM slave with 32-bit data.
*/
// Summary of operation
// - Single-channel select keeps only channel A running.
// - Upper-pair enable, reset one, gates channels C, D.
// - Lower-pair enable, reset one, gates channels A, B.
// - Pair off: lanes halved rounding up, converters halved.
// - Odd lane count, pair off: add tail bits.
// - Lower pair off: C, D use A, B slots.
// - Sync-header field: 0 CRC-12, 2 FEC, others reserved.
// - Sync-header choice applies only in 64B/66B formats.
// - All command fields of sync word driven zero.
`ifndef CHAN_CFG_CONSTS_VH
`define CHAN_CFG_CONSTS_VH

`define ADDR_W            12
`define IDX_SYNC_HDR      12'h20F
`define IDX_CHAN_PAIR     12'h209
`define RST_SYNC_HDR      8'h00
`define RST_CHAN_PAIR     8'h03
`define BIT_LOWER_EN      0
`define BIT_UPPER_EN      1
`define BIT_SINGLE_CH     2
`define BE_LOW_LANE       0
`define NUM_CHAN          4
`define CHAN_A            0
`define CHAN_B            1
`define CHAN_C            2
`define CHAN_D            3
`define SH_CRC12          2'h0
`define SH_FEC            2'h2
`define SH_OUT_CRC12      2'h1
`define SH_OUT_FEC        2'h2
`define SH_OUT_NONE       2'h0
`define UNMAPPED_DATA     32'h00000000

`endif

// *** rtl/channel_enable_syncword_config.v ***
/*
  Register bank for channel-pair enabling and 64B/66B sync-word mode.
  Assumes an Avalon-MM master on clk_sys_i and a link engine that reads the
  derived lane, converter, sample-routing and sync-header controls.
*/
`timescale 1ns/10ps
`default_nettype none
`include "chan_cfg_consts.vh"

module channel_enable_syncword_config (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // Avalon-MM slave
  input  wire [13:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  // Link configuration from the rest of the device
  input  wire [4:0]  full_lane_count_i,
  input  wire [4:0]  full_conv_count_i,
  input  wire        link_is_64b66b_i,
  // Derived controls toward the channels and the link engine
  output reg         chan_a_enable_o,
  output reg         chan_b_enable_o,
  output reg         chan_c_enable_o,
  output reg         chan_d_enable_o,
  output reg         single_channel_mode_o,
  output reg  [4:0]  active_lane_count_o,
  output reg  [4:0]  active_conv_count_o,
  output reg         tail_bits_enable_o,
  output reg         cd_to_ab_slots_o,
  output reg  [1:0]  sync_word_kind_o,
  output reg         sync_cmd_zero_o
);

  // Bus handshake states; every access spends one cycle in the answer state.
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  reg  [7:0]  channel_pair_control;
  reg  [7:0]  sync_header_select_cfg;
  reg         bus_state;
  reg         next_bus_state;
  reg         next_waitrequest;
  reg  [31:0] next_readdata;
  reg  [7:0]  next_channel_pair_control;
  reg  [7:0]  next_sync_header_select_cfg;
  reg  [4:0]  next_active_lane_count;
  reg  [4:0]  next_active_conv_count;
  reg  [1:0]  next_sync_word_kind;
  wire [3:0]  next_chan_enable;
  wire        next_tail_bits;
  wire        next_cd_to_ab;
  wire [11:0] word_index;
  wire        request;
  wire        answering;
  wire        write_commit;
  wire        read_launch;
  wire        lower_en;
  wire        upper_en;
  wire        single_ch;
  wire        pair_off;
  genvar      ch;

  // True when a word index selects the given register.
  function index_hit;
    input [11:0] index;
    input [11:0] target;
    begin
      index_hit = (index == target);
    end
  endfunction

  // Maps the stored field onto the sync-word kind; reserved codes send none.
  function [1:0] sync_kind;
    input [1:0] sel;
    begin
      case (sel)
        `SH_CRC12: sync_kind = `SH_OUT_CRC12;
        `SH_FEC:   sync_kind = `SH_OUT_FEC;
        default:   sync_kind = `SH_OUT_NONE;
      endcase
    end
  endfunction

  // Whether a channel may run, given both pair enables and single mode.
  // Single mode keeps only channel A; a broken pair setting is not masked.
  function chan_allowed;
    input integer chan;
    input         lower;
    input         upper;
    input         single;
    begin
      case (chan)
        `CHAN_A: chan_allowed = lower;
        `CHAN_B: chan_allowed = lower & ~single;
        `CHAN_C: chan_allowed = upper & ~single;
        `CHAN_D: chan_allowed = upper & ~single;
        default: chan_allowed = 1'b0;
      endcase
    end
  endfunction

  // Lane count with one pair off: half of the full count, rounded up.
  function [4:0] half_round_up;
    input [4:0] count;
    begin
      half_round_up = (count >> 1) + {4'h0, count[0]};
    end
  endfunction

  // Converter count with one pair off: half of the full count.
  function [4:0] half_round_down;
    input [4:0] count;
    begin
      half_round_down = count >> 1;
    end
  endfunction

  assign word_index   = avs_address_i[13:2];
  assign request      = avs_read_i | avs_write_i;
  assign answering    = (bus_state == BUS_ANSWER);
  assign write_commit = answering & avs_write_i & avs_byteenable_i[`BE_LOW_LANE];
  assign read_launch  = ~answering & avs_read_i;

  assign lower_en  = channel_pair_control[`BIT_LOWER_EN];
  assign upper_en  = channel_pair_control[`BIT_UPPER_EN];
  assign single_ch = channel_pair_control[`BIT_SINGLE_CH];
  assign pair_off  = ~lower_en | ~upper_en;

  // An access is taken in the idle state and answered one cycle later, on
  // the edge where the master sees waitrequest low.
  always @* begin
    next_bus_state   = BUS_IDLE;
    next_waitrequest = 1'b1;
    case (bus_state)
      BUS_IDLE: begin
        if (request) begin
          next_bus_state   = BUS_ANSWER;
          next_waitrequest = 1'b0;
        end
      end
      BUS_ANSWER: begin
        next_bus_state   = BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_bus_state   = BUS_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= next_waitrequest;
    end
  end

  // Unmapped indices read as zero.
  always @* begin
    next_readdata = `UNMAPPED_DATA;
    if (index_hit(word_index, `IDX_CHAN_PAIR)) begin
      next_readdata = {24'h000000, channel_pair_control};
    end else if (index_hit(word_index, `IDX_SYNC_HDR)) begin
      next_readdata = {24'h000000, sync_header_select_cfg};
    end
  end

  // Read data is loaded as the access is taken and stands until the next
  // read, so it is still valid on the edge that ends the wait.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= `UNMAPPED_DATA;
    end else if (read_launch) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // Writes land on the edge that ends the wait. Reserved bits are kept as
  // written, so software reads back exactly what it stored.
  always @* begin
    next_channel_pair_control   = channel_pair_control;
    next_sync_header_select_cfg = sync_header_select_cfg;
    if (write_commit) begin
      if (index_hit(word_index, `IDX_CHAN_PAIR)) begin
        next_channel_pair_control = avs_writedata_i[7:0];
      end
      if (index_hit(word_index, `IDX_SYNC_HDR)) begin
        next_sync_header_select_cfg = avs_writedata_i[7:0];
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      channel_pair_control <= `RST_CHAN_PAIR;
    end else begin
      channel_pair_control <= next_channel_pair_control;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_header_select_cfg <= `RST_SYNC_HDR;
    end else begin
      sync_header_select_cfg <= next_sync_header_select_cfg;
    end
  end

  // Per-channel run enables.
  generate
    for (ch = 0; ch < `NUM_CHAN; ch = ch + 1) begin : gen_chan_enable
      assign next_chan_enable[ch] = chan_allowed(ch, lower_en, upper_en, single_ch);
    end
  endgenerate

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_a_enable_o <= 1'b1;
    end else begin
      chan_a_enable_o <= next_chan_enable[`CHAN_A];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_b_enable_o <= 1'b1;
    end else begin
      chan_b_enable_o <= next_chan_enable[`CHAN_B];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_c_enable_o <= 1'b1;
    end else begin
      chan_c_enable_o <= next_chan_enable[`CHAN_C];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_d_enable_o <= 1'b1;
    end else begin
      chan_d_enable_o <= next_chan_enable[`CHAN_D];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      single_channel_mode_o <= 1'b0;
    end else begin
      single_channel_mode_o <= single_ch;
    end
  end

  // Counts shrink when either pair is off; the full counts come from outside.
  always @* begin
    next_active_lane_count = full_lane_count_i;
    next_active_conv_count = full_conv_count_i;
    if (pair_off) begin
      next_active_lane_count = half_round_up(full_lane_count_i);
      next_active_conv_count = half_round_down(full_conv_count_i);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      active_lane_count_o <= 5'h00;
    end else begin
      active_lane_count_o <= next_active_lane_count;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      active_conv_count_o <= 5'h00;
    end else begin
      active_conv_count_o <= next_active_conv_count;
    end
  end

  // With either pair off, an odd full lane count leaves the highest lane short; tail bits pad it.
  assign next_tail_bits = pair_off & full_lane_count_i[0];

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tail_bits_enable_o <= 1'b0;
    end else begin
      tail_bits_enable_o <= next_tail_bits;
    end
  end

  assign next_cd_to_ab = ~lower_en;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cd_to_ab_slots_o <= 1'b0;
    end else begin
      cd_to_ab_slots_o <= next_cd_to_ab;
    end
  end

  // The sync-header choice only matters in 64B/66B formats.
  always @* begin
    next_sync_word_kind = `SH_OUT_NONE;
    if (link_is_64b66b_i) begin
      next_sync_word_kind = sync_kind(sync_header_select_cfg[1:0]);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_word_kind_o <= `SH_OUT_NONE;
    end else begin
      sync_word_kind_o <= next_sync_word_kind;
    end
  end

  // No command-channel features: the command fields always send idle zeros.
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_cmd_zero_o <= 1'b1;
    end else begin
      sync_cmd_zero_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** testbench/chan_cfg_checker.sv ***
/* Port assertions for the channel-pair and sync-word bank.
   Assumes one clock domain and a bind from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module chan_cfg_checker (
  // Clock, reset and bus
  input wire logic       clk_sys_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  // Link inputs and derived outputs
  input wire logic [4:0] full_lane_count_i, active_lane_count_o,
  input wire logic       link_is_64b66b_i, chan_b_enable_o, chan_c_enable_o, chan_d_enable_o,
  input wire logic       single_channel_mode_o, tail_bits_enable_o, cd_to_ab_slots_o,
  input wire logic [1:0] sync_word_kind_o,
  input wire logic       sync_cmd_zero_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_cmd_zero: assert property (sync_cmd_zero_o)
    else $error("command fields not zero");
  a_single_off: assert property (single_channel_mode_o |->
    !(chan_b_enable_o | chan_c_enable_o | chan_d_enable_o)) else $error("single mode leak");
  a_pair_cd: assert property (chan_c_enable_o == chan_d_enable_o)
    else $error("c and d split");
  a_half_lanes: assert property (cd_to_ab_slots_o && $past(rst_n_i) |->
    active_lane_count_o == ({1'b0, $past(full_lane_count_i)} + 6'h01) >> 1) else $error("lanes");
  a_tail_odd: assert property (tail_bits_enable_o |-> $past(full_lane_count_i[0]))
    else $error("tail bits on even count");
  a_kind_gate: assert property (!$past(link_is_64b66b_i) |-> sync_word_kind_o == 2'h0)
    else $error("sync kind outside 64b66b");
  a_kind_legal: assert property (sync_word_kind_o != 2'h3)
    else $error("sync kind illegal");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  a_wait_ans: assert property ($rose(avs_read_i | avs_write_i) |=> !avs_waitrequest_o)
    else $error("no answer");
endmodule
`default_nettype wire

// *** testbench/tb_channel_enable_syncword_config.sv ***
/* Self-checking bench for the channel-pair and sync-word bank.
   Drives the bus and link inputs itself; binds the checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_channel_enable_syncword_config;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        link_is_64b66b_i = 1'b0, avs_waitrequest_o, tail_bits_enable_o, sync_cmd_zero_o;
  logic        chan_a_enable_o, chan_b_enable_o, chan_c_enable_o, chan_d_enable_o;
  logic        single_channel_mode_o, cd_to_ab_slots_o;
  logic [13:0] avs_address_i = 14'h0000;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [4:0]  full_lane_count_i = 5'h00, full_conv_count_i = 5'h00;
  logic [4:0]  active_lane_count_o, active_conv_count_o;
  logic [1:0]  sync_word_kind_o;
  logic [7:0]  cp, sh;
  logic [31:0] rd;
  int          failures = 0, total_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  channel_enable_syncword_config DUT (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .full_lane_count_i, .full_conv_count_i, .link_is_64b66b_i, .chan_a_enable_o,
    .chan_b_enable_o, .chan_c_enable_o, .chan_d_enable_o, .single_channel_mode_o,
    .active_lane_count_o, .active_conv_count_o, .tail_bits_enable_o, .cd_to_ab_slots_o,
    .sync_word_kind_o, .sync_cmd_zero_o);
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [1:0] exp_kind(input logic fmt, input logic [1:0] s);
    return !fmt ? 2'h0 : (s == 2'h0) ? 2'h1 : (s == 2'h2) ? 2'h2 : 2'h0;
  endfunction
  task acc(input logic w, input [13:0] ad, input [7:0] dv);
    avs_address_i <= ad;
    avs_writedata_i <= {24'h0, dv};
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task close_out;
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    close_out;
  end
  initial begin
    void'($urandom(32'hFDE6));
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    acc(0, 14'h0824, 8'h00);
    chk(rd, 32'h03, "pair reset");
    acc(0, 14'h083C, 8'h00);
    chk(rd, 32'h00, "sync reset");
    for (int i = 0; i < 24; i++) begin
      cp = {6'h00, 2'($urandom_range(3, 1))};
      cp[2] = cp[0] & 1'($urandom);
      if (i == 1) cp = 8'h02;
      if (i == 2) cp = 8'h05;
      sh = (i < 4) ? 8'(i) : {6'h00, 2'($urandom)};
      link_is_64b66b_i <= (i < 4) || 1'($urandom);
      full_lane_count_i <= 5'($urandom);
      full_conv_count_i <= 5'($urandom);
      acc(1, 14'h0824, cp);
      acc(1, 14'h083C, sh);
      acc(0, 14'h0824, 8'h00);
      chk(rd, {24'h0, cp}, "pair reg");
      chk({single_channel_mode_o, chan_a_enable_o, chan_b_enable_o, chan_c_enable_o,
        chan_d_enable_o}, {cp[2], cp[0], cp[0] & !cp[2], {2{cp[1] & !cp[2]}}}, "enables");
      chk(cd_to_ab_slots_o, !cp[0], "slots");
      if (!cp[2]) begin
        chk(active_lane_count_o, (cp[1:0] == 2'h3) ? full_lane_count_i
          : 5'((full_lane_count_i + 6'h01) >> 1), "lanes");
        chk(active_conv_count_o, (cp[1:0] == 2'h3) ? full_conv_count_i
          : full_conv_count_i >> 1, "convs");
        chk(tail_bits_enable_o, cp[1:0] != 2'h3 && full_lane_count_i[0], "tail");
      end
      chk(sync_word_kind_o, exp_kind(link_is_64b66b_i, sh[1:0]), "kind");
    end
    acc(1, 14'h0820, 8'hFF);
    acc(0, 14'h0820, 8'h00);
    chk(rd, 32'h0, "unmapped");
    avs_byteenable_i <= 4'hE;
    acc(1, 14'h0824, 8'h01);
    acc(0, 14'h0824, 8'h00);
    chk(rd, {24'h0, cp}, "byte lane");
    close_out;
  end
endmodule
bind channel_enable_syncword_config chan_cfg_checker u_chk (.clk_sys_i, .rst_n_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .full_lane_count_i, .active_lane_count_o,
  .link_is_64b66b_i, .chan_b_enable_o, .chan_c_enable_o, .chan_d_enable_o,
  .single_channel_mode_o, .tail_bits_enable_o, .cd_to_ab_slots_o, .sync_word_kind_o,
  .sync_cmd_zero_o);
`default_nettype wire
